// ==== flush_if.sv ====
// request and status carrier between control logic and the flush walker
`timescale 1ns/1ps
interface flush_if #(
  parameter int unsigned PORT_W = 2,
  parameter int unsigned INST_W = 3
);
  import lookup_pkg::*;
  logic               start;
  flush_scope_e       scope;
  logic [1:0]         option;
  logic [PORT_W-1:0]  port;
  logic [INST_W-1:0]  inst;
  logic               done;

  modport ctl (output start, scope, option, port, inst, input done);
  modport eng (input start, scope, option, port, inst, output done);
endinterface

// ==== flush_walker.sv ====
// walks every lookup table index once per flush request whose option is not 00
`timescale 1ns/1ps
module flush_walker #(
  parameter int unsigned TABLE_DEPTH = 1024,
  parameter int unsigned PORT_W      = 2,
  parameter int unsigned INST_W      = 3,
  parameter int unsigned IDX_W       = $clog2(TABLE_DEPTH)
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  flush_if.eng                           fi,
  output logic                           tbl_flush_valid,
  output logic [IDX_W-1:0]               tbl_flush_index,
  output logic                           tbl_flush_dynamic,
  output logic                           tbl_flush_static,
  output lookup_pkg::flush_scope_e       tbl_flush_scope,
  output logic [PORT_W-1:0]              tbl_flush_port,
  output logic [INST_W-1:0]              tbl_flush_inst
);
  import lookup_pkg::*;

  typedef enum logic {W_IDLE, W_WALK} walk_e;

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(TABLE_DEPTH - 1);

  walk_e              st_r, st_nxt;
  logic [IDX_W-1:0]   idx_r, idx_nxt;
  logic [1:0]         opt_r, opt_nxt;
  flush_scope_e       scope_r, scope_nxt;
  logic [PORT_W-1:0]  port_r, port_nxt;
  logic [INST_W-1:0]  inst_r, inst_nxt;
  logic               done_r, done_nxt;

  always_comb begin
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    opt_nxt   = opt_r;
    scope_nxt = scope_r;
    port_nxt  = port_r;
    inst_nxt  = inst_r;
    done_nxt  = 1'b0;
    unique case (st_r)
      W_IDLE: begin
        if (fi.start) begin
          scope_nxt = fi.scope;
          port_nxt  = fi.port;
          inst_nxt  = fi.inst;
          opt_nxt   = fi.option;
          idx_nxt   = '0;
          // option 00 removes nothing, so it finishes at once
          if (fi.option == FLUSH_NONE) begin
            done_nxt = 1'b1;
          end else begin
            st_nxt = W_WALK;
          end
        end
      end
      W_WALK: begin
        if (idx_r == LAST_IDX) begin
          st_nxt   = W_IDLE;
          done_nxt = 1'b1;
        end else begin
          idx_nxt = idx_r + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r    <= W_IDLE;
      idx_r   <= '0;
      opt_r   <= FLUSH_NONE;
      scope_r <= SCOPE_ALL;
      port_r  <= '0;
      inst_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      opt_r   <= opt_nxt;
      scope_r <= scope_nxt;
      port_r  <= port_nxt;
      inst_r  <= inst_nxt;
      done_r  <= done_nxt;
    end
  end

  assign fi.done           = done_r;
  assign tbl_flush_valid   = (st_r == W_WALK);
  assign tbl_flush_index   = idx_r;
  // only the lookup table is walked; static table has no port here
  assign tbl_flush_dynamic = opt_r[0];
  assign tbl_flush_static  = opt_r[1];
  assign tbl_flush_scope   = scope_r;
  assign tbl_flush_port    = port_r;
  assign tbl_flush_inst    = inst_r;
endmodule

// ==== lookup_engine_control_one.sv ====
// lookup engine control one register, flush sequencing and frame verdicts
// Overview of operation
// - while bit 7 is set no unicast source address is learned; clear after reset.
// - with self filtering in force a frame whose source equals the switch address is dropped.
// - self filtering acts only on ports with their enable set and global bit 6 set.
// - writing 1 to self-clearing bit 5 starts a flush of the whole lookup table; it reads 0 normally.
// - the whole table flush never touches the separate static address table.
// - writing 1 to self-clearing bit 4 flushes only entries of the selected spanning-tree instance.
// - both flushes take the flush option field of control two to pick dynamic, static or both.
// - option 01 is dynamic, 10 static, 11 both, 00 no flush or finished.
// - bit 3 clear drops frames with a multicast source; set, the reset value, forwards them.
// - bit 2 set, the reset value, enables aging; clear suspends all aging.
// - bit 1 set selects fast aging; clear, the reset value, keeps the normal rate.
// - with bit 0 set a port whose link goes down has its dynamic entries flushed; clear after reset.
`timescale 1ns/1ps
module lookup_engine_control_one #(
  parameter int unsigned NPORTS      = 4,
  parameter int unsigned TABLE_DEPTH = 1024,
  parameter int unsigned INST_W      = 3,
  parameter int unsigned PORT_W      = (NPORTS > 1) ? $clog2(NPORTS) : 1,
  parameter int unsigned IDX_W       = $clog2(TABLE_DEPTH)
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [47:0]           self_mac,
  input  wire logic [NPORTS-1:0]     port_self_filter_en,
  input  wire logic [NPORTS-1:0]     link_up,
  input  wire logic                  rx_valid,
  input  wire logic [PORT_W-1:0]     rx_port,
  input  wire logic [47:0]           rx_src_mac,
  output logic                       rx_verdict_valid,
  output logic                       rx_drop,
  output logic                       rx_learn,
  output logic                       aging_enable,
  output logic                       fast_aging,
  output logic                       tbl_flush_valid,
  output logic [IDX_W-1:0]           tbl_flush_index,
  output logic                       tbl_flush_dynamic,
  output logic                       tbl_flush_static,
  output lookup_pkg::flush_scope_e   tbl_flush_scope,
  output logic [PORT_W-1:0]          tbl_flush_port,
  output logic [INST_W-1:0]          tbl_flush_inst
);
  import lookup_pkg::*;
  function automatic reg_sel_e reg_decode(input logic [11:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'b00};
    return (word == CTRL1_ADDR) ? SEL_CTRL1 :
           (word == CTRL2_ADDR) ? SEL_CTRL2 :
           (word == INST_ADDR)  ? SEL_INST  : SEL_NONE;
  endfunction
  // bus slave state
  logic               aw_hold_r, aw_hold_nxt;
  logic [11:0]        aw_addr_r, aw_addr_nxt;
  logic               w_hold_r, w_hold_nxt;
  logic [7:0]         w_data_r, w_data_nxt;
  logic               w_lane_r, w_lane_nxt;
  logic               bvalid_r, bvalid_nxt;
  logic [1:0]         bresp_r, bresp_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic [1:0]         rresp_r, rresp_nxt;
  logic               wr_fire;
  reg_sel_e           wr_sel;
  // control state
  logic [7:0]         ctrl1_r, ctrl1_nxt;
  logic [7:0]         ctrl2_r, ctrl2_nxt;
  logic [INST_W-1:0]  inst_r, inst_nxt;
  logic               pend_all_r, pend_all_nxt;
  logic               pend_inst_r, pend_inst_nxt;
  logic [NPORTS-1:0]  pend_port_r, pend_port_nxt;
  logic               run_r, run_nxt;
  flush_scope_e       run_scope_r, run_scope_nxt;
  logic [PORT_W-1:0]  run_port_r, run_port_nxt;
  logic [7:0]         ctrl1_view;
  // link state
  logic [NPORTS-1:0]  link_s1_r, link_s2_r, link_last_r;
  logic [NPORTS-1:0]  link_down;
  // frame verdict state
  logic               rx_done_r, rx_done_nxt;
  logic               rx_drop_r, rx_drop_nxt;
  logic               rx_learn_r, rx_learn_nxt;
  flush_if #(.PORT_W(PORT_W), .INST_W(INST_W)) fi ();
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_sel        = reg_decode(aw_addr_r);
  // triggers show their pending state, which holds until the walk ends
  assign ctrl1_view = {ctrl1_r[7:6], pend_all_r, pend_inst_r, ctrl1_r[3:0]};
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_lane_nxt  = w_lane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (reg_decode(s_axi_araddr))
        SEL_CTRL1: rdata_nxt = {24'h00_0000, ctrl1_view};
        SEL_CTRL2: rdata_nxt = {24'h00_0000, ctrl2_r};
        SEL_INST:  rdata_nxt = {{(32 - INST_W){1'b0}}, inst_r};
        SEL_NONE: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_lane_r  <= w_lane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end
  // link status comes from the phys, so it is resynchronised first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_s1_r   <= '0;
      link_s2_r   <= '0;
      link_last_r <= '0;
    end else begin
      link_s1_r   <= link_up;
      link_s2_r   <= link_s1_r;
      link_last_r <= link_s2_r;
    end
  end
  assign link_down = link_last_r & ~link_s2_r;
  // one flush runs at a time: whole table, then instance, then lowest port
  always_comb begin
    ctrl1_nxt     = ctrl1_r;
    ctrl2_nxt     = ctrl2_r;
    inst_nxt      = inst_r;
    pend_all_nxt  = pend_all_r;
    pend_inst_nxt = pend_inst_r;
    pend_port_nxt = pend_port_r;
    run_nxt       = run_r;
    run_scope_nxt = run_scope_r;
    run_port_nxt  = run_port_r;
    fi.start      = 1'b0;
    fi.scope      = SCOPE_ALL;
    fi.option     = ctrl2_r[FLUSH_OPT_LSB +: 2];
    fi.port       = '0;
    fi.inst       = inst_r;
    if (run_r && fi.done) begin
      run_nxt = 1'b0;
      unique case (run_scope_r)
        SCOPE_ALL:  pend_all_nxt = 1'b0;
        SCOPE_INST: pend_inst_nxt = 1'b0;
        SCOPE_PORT: pend_port_nxt[run_port_r] = 1'b0;
      endcase
    end else if (!run_r) begin
      if (pend_all_r) begin
        fi.start = 1'b1;
        fi.scope = SCOPE_ALL;
      end else if (pend_inst_r) begin
        fi.start = 1'b1;
        fi.scope = SCOPE_INST;
      end else if (|pend_port_r) begin
        fi.start  = 1'b1;
        fi.scope  = SCOPE_PORT;
        fi.option = FLUSH_DYN;
        for (int i = NPORTS - 1; i >= 0; i--) begin
          if (pend_port_r[i]) begin
            fi.port = PORT_W'(i);
          end
        end
      end
      run_nxt       = fi.start;
      run_scope_nxt = fi.scope;
      run_port_nxt  = fi.port;
    end
    // a new link loss wins over the clear of the same port
    if (ctrl1_r[BIT_LINK_FLUSH]) begin
      pend_port_nxt = pend_port_nxt | link_down;
    end
    if (wr_fire && w_lane_r) begin
      unique case (wr_sel)
        SEL_CTRL1: begin
          ctrl1_nxt = w_data_r & ~(8'h01 << BIT_FLUSH_ALL) & ~(8'h01 << BIT_FLUSH_INST);
          // a 1 written while a flush of the same kind runs is absorbed by that flush, except in the cycle its done arrives, which queues another
          if (w_data_r[BIT_FLUSH_ALL]) begin
            pend_all_nxt = 1'b1;
          end
          if (w_data_r[BIT_FLUSH_INST]) begin
            pend_inst_nxt = 1'b1;
          end
        end
        SEL_CTRL2: ctrl2_nxt = w_data_r;
        SEL_INST:  inst_nxt = w_data_r[INST_W-1:0];
        SEL_NONE: begin
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_r     <= CTRL1_RST;
      ctrl2_r     <= CTRL2_RST;
      inst_r      <= INST_RST[INST_W-1:0];
      pend_all_r  <= 1'b0;
      pend_inst_r <= 1'b0;
      pend_port_r <= '0;
      run_r       <= 1'b0;
      run_scope_r <= SCOPE_ALL;
      run_port_r  <= '0;
    end else begin
      ctrl1_r     <= ctrl1_nxt;
      ctrl2_r     <= ctrl2_nxt;
      inst_r      <= inst_nxt;
      pend_all_r  <= pend_all_nxt;
      pend_inst_r <= pend_inst_nxt;
      pend_port_r <= pend_port_nxt;
      run_r       <= run_nxt;
      run_scope_r <= run_scope_nxt;
      run_port_r  <= run_port_nxt;
    end
  end
  flush_walker #(
    .TABLE_DEPTH (TABLE_DEPTH),
    .PORT_W      (PORT_W),
    .INST_W      (INST_W),
    .IDX_W       (IDX_W)
  ) u_walker (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .fi                (fi),
    .tbl_flush_valid   (tbl_flush_valid),
    .tbl_flush_index   (tbl_flush_index),
    .tbl_flush_dynamic (tbl_flush_dynamic),
    .tbl_flush_static  (tbl_flush_static),
    .tbl_flush_scope   (tbl_flush_scope),
    .tbl_flush_port    (tbl_flush_port),
    .tbl_flush_inst    (tbl_flush_inst)
  );
  // frame verdict one cycle after the source address is offered
  always_comb begin
    logic self_hit;
    logic mc_src;
    self_hit = 1'b0;
    mc_src   = rx_src_mac[40];
    if (ctrl1_r[BIT_SELF_FILT] && port_self_filter_en[rx_port]) begin
      self_hit = (rx_src_mac == self_mac);
    end
    rx_done_nxt  = rx_valid;
    rx_drop_nxt  = self_hit || (mc_src && !ctrl1_r[BIT_MC_FWD]);
    rx_learn_nxt = rx_valid && !ctrl1_r[BIT_LEARN_DIS] && !mc_src && !rx_drop_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_done_r  <= 1'b0;
      rx_drop_r  <= 1'b0;
      rx_learn_r <= 1'b0;
    end else begin
      rx_done_r  <= rx_done_nxt;
      rx_drop_r  <= rx_drop_nxt;
      rx_learn_r <= rx_learn_nxt;
    end
  end
  assign rx_verdict_valid = rx_done_r;
  assign rx_drop          = rx_drop_r;
  assign rx_learn         = rx_learn_r;
  assign aging_enable     = ctrl1_r[BIT_AGE_EN];
  assign fast_aging       = ctrl1_r[BIT_FAST_AGE];
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
endmodule

// ==== lookup_engine_control_one_monitor.sv ====
// concurrent checks on frame verdicts and the flush walk
`timescale 1ns/1ps
module lookup_engine_control_one_monitor
  import lookup_pkg::*;
#(
  parameter int unsigned TABLE_DEPTH = 1024,
  parameter int unsigned PORT_W      = 2,
  parameter int unsigned IDX_W       = $clog2(TABLE_DEPTH)
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                rx_valid,
  input wire logic [47:0]         rx_src_mac,
  input wire logic                rx_verdict_valid,
  input wire logic                rx_drop,
  input wire logic                rx_learn,
  input wire logic                tbl_flush_valid,
  input wire logic [IDX_W-1:0]    tbl_flush_index,
  input wire logic                tbl_flush_dynamic,
  input wire logic                tbl_flush_static,
  input wire lookup_pkg::flush_scope_e tbl_flush_scope,
  input wire logic [PORT_W-1:0]   tbl_flush_port
);
  localparam logic [IDX_W-1:0] LAST = IDX_W'(TABLE_DEPTH - 1);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_verdict_next: assert property (rx_valid |=> rx_verdict_valid)
    else $error("no verdict one cycle after a frame");
  a_verdict_only: assert property (!rx_valid |=> !rx_verdict_valid)
    else $error("verdict without a frame");
  a_drop_no_learn: assert property (rx_verdict_valid && rx_drop |-> !rx_learn)
    else $error("dropped frame was learned");
  a_mc_no_learn: assert property (rx_valid && rx_src_mac[40] |=> !rx_learn)
    else $error("multicast source was learned");
  a_walk_option: assert property (tbl_flush_valid |-> tbl_flush_dynamic || tbl_flush_static)
    else $error("walk with empty option");
  a_walk_first: assert property ($rose(tbl_flush_valid) |-> tbl_flush_index == '0)
    else $error("walk does not start at index zero");
  a_walk_step: assert property (tbl_flush_valid && tbl_flush_index != LAST
    |=> tbl_flush_valid && tbl_flush_index == $past(tbl_flush_index) + 1'b1)
    else $error("walk index skipped or stopped early");
  a_walk_end: assert property (tbl_flush_valid && tbl_flush_index == LAST |=> !tbl_flush_valid)
    else $error("walk ran past the last index");
  a_walk_stable: assert property (tbl_flush_valid ##1 tbl_flush_valid
    |-> $stable(tbl_flush_scope) && $stable(tbl_flush_dynamic) && $stable(tbl_flush_static) && $stable(tbl_flush_port))
    else $error("walk attributes changed mid walk");
  a_port_dynamic: assert property (tbl_flush_valid && tbl_flush_scope == SCOPE_PORT
    |-> tbl_flush_dynamic && !tbl_flush_static)
    else $error("link down walk not dynamic only");
endmodule

// ==== lookup_engine_control_one_tb_top.sv ====
// self-checking bench for the lookup engine control register block
`timescale 1ns/1ps
module lookup_engine_control_one_tb_top;
  import lookup_pkg::*;
  localparam int unsigned DEPTH = 8;
  logic         aclk = 0;
  logic         aresetn = 0;
  logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'hf;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [47:0]  self_mac = '0, rx_src_mac = '0;
  logic [3:0]   port_self_filter_en = '0, link_up = '0;
  logic         rx_valid = 0;
  logic [1:0]   rx_port = '0, tbl_flush_port;
  logic         rx_verdict_valid, rx_drop, rx_learn, aging_enable, fast_aging;
  logic         tbl_flush_valid, tbl_flush_dynamic, tbl_flush_static;
  logic [2:0]   tbl_flush_index, tbl_flush_inst;
  flush_scope_e tbl_flush_scope;
  logic [31:0]  seed = 32'h0000_7859;
  int           n_errors = 0, num_checks = 0, cyc = 0, walks = 0;
  logic         fv_d = 0;
  logic [8:0]   wcap = '0;
  logic [7:0]   wlen = '0;
  logic [17:0]  rq[$];
  logic [1:0]   bq[$], vq[$];
  logic [7:0]   cfg[5] = '{8'h0c, 8'h40, 8'h48, 8'h86, 8'hce};

  always #2 aclk = ~aclk;

  lookup_engine_control_one #(.TABLE_DEPTH(DEPTH)) i_lookup_engine_control_one (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .self_mac, .port_self_filter_en, .link_up, .rx_valid,
    .rx_port, .rx_src_mac, .rx_verdict_valid, .rx_drop, .rx_learn, .aging_enable, .fast_aging, .tbl_flush_valid,
    .tbl_flush_index, .tbl_flush_dynamic, .tbl_flush_static, .tbl_flush_scope, .tbl_flush_port, .tbl_flush_inst);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // results land in queue order, so drivers only push and this block only pops
  always @(posedge aclk) begin
    if (rx_verdict_valid) chk("verdict", vq.pop_front(), {rx_drop, rx_learn});
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata[15:0]});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", bq.pop_front(), s_axi_bresp);
    if (tbl_flush_valid && !fv_d) begin
      walks++;
      wcap <= {tbl_flush_scope, tbl_flush_dynamic, tbl_flush_static, tbl_flush_port, tbl_flush_inst};
      wlen <= 8'd1;
    end else if (tbl_flush_valid) begin
      wlen <= wlen + 8'd1;
    end
    fv_d <= tbl_flush_valid;
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    bq.push_back(e);
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) s_axi_awvalid <= 0;
      if (pw && s_axi_wready) s_axi_wvalid <= 0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [17:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    rq.push_back(e);
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask

  // back-to-back frames: self address, random unicast and multicast sources
  task automatic frames(input logic [7:0] c);
    logic [47:0] s;
    logic [3:0]  en;
    logic        d;
    wr(CTRL1_ADDR, c, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("aging", {c[2], c[1]}, {aging_enable, fast_aging});
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      en = seed[11:8];
      s = (seed[3:2] == 2'd0) ? self_mac : {seed[15:0], seed};
      d = (c[6] & en[seed[1:0]] & (s == self_mac)) | (s[40] & !c[3]);
      @(posedge aclk);
      rx_valid <= 1;
      rx_port <= seed[1:0];
      rx_src_mac <= s;
      port_self_filter_en <= en;
      vq.push_back({d, !c[7] & !s[40] & !d});
    end
    @(posedge aclk);
    rx_valid <= 0;
  endtask

  task automatic walk(input flush_scope_e sc, input logic [1:0] o, input logic [2:0] t, input int w);
    int n;
    n = 0;
    while ((walks == w || tbl_flush_valid) && n < 100) begin
      @(posedge aclk);
      n++;
    end
    repeat (4) @(posedge aclk);
    chk("walk", {sc, o[0], o[1], t, 8'(DEPTH)}, {wcap[8:5], (sc == SCOPE_PORT) ? {1'b0, wcap[4:3]} :
        (sc == SCOPE_INST) ? wcap[2:0] : 3'h0, wlen});
  endtask

  initial begin
    int w;
    logic [7:0] tr;
    repeat (3) @(posedge aclk);
    chk("aging", 2'b10, {aging_enable, fast_aging});
    aresetn <= 1;
    seed = lfsr(seed);
    self_mac <= {8'h02, seed[7:0], seed};
    link_up <= 4'hf;
    rd(CTRL1_ADDR, {RESP_OKAY, 16'h000c});
    rd(CTRL2_ADDR, {RESP_OKAY, 16'h0000});
    rd(12'h004, {RESP_SLVERR, 16'h0000});
    wr(12'h004, 8'hff, RESP_SLVERR);
    wr(CTRL2_ADDR, 8'ha3, RESP_OKAY);
    // byte lane 0 off: answered, but the register keeps its value
    s_axi_wstrb <= 4'he;
    wr(CTRL2_ADDR, 8'h5c, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(CTRL2_ADDR, {RESP_OKAY, 16'h00a3});
    foreach (cfg[i]) frames(cfg[i]);
    // every option against both triggers; option zero must not walk at all
    for (int k = 0; k < 8; k++) begin
      tr = k[0] ? 8'h10 : 8'h20;
      seed = lfsr(seed);
      wr(CTRL2_ADDR, {4'h0, k[2:1], 2'b00}, RESP_OKAY);
      wr(INST_ADDR, {5'h0, seed[2:0]}, RESP_OKAY);
      w = walks;
      wr(CTRL1_ADDR, 8'h0c | tr, RESP_OKAY);
      if (k[2:1] != 2'b00) begin
        rd(CTRL1_ADDR, {RESP_OKAY, 8'h00, 8'h0c | tr});
        walk(k[0] ? SCOPE_INST : SCOPE_ALL, k[2:1], k[0] ? seed[2:0] : 3'h0, w);
      end else begin
        repeat (12) @(posedge aclk);
        chk("walks", 24'(w), 24'(walks));
      end
      rd(CTRL1_ADDR, {RESP_OKAY, 16'h000c});
    end
    w = walks;
    link_up[1] <= 1'b0;
    repeat (12) @(posedge aclk);
    chk("walks", 24'(w), 24'(walks));
    link_up[1] <= 1'b1;
    wr(CTRL1_ADDR, 8'h0d, RESP_OKAY);
    repeat (4) @(posedge aclk);
    w = walks;
    link_up[2] <= 1'b0;
    walk(SCOPE_PORT, 2'b01, 3'h2, w);
    final_report();
  end
endmodule

bind lookup_engine_control_one lookup_engine_control_one_monitor #(
  .TABLE_DEPTH(TABLE_DEPTH), .PORT_W(PORT_W), .IDX_W(IDX_W)) i_mon (
  .aclk, .aresetn, .rx_valid, .rx_src_mac, .rx_verdict_valid, .rx_drop, .rx_learn, .tbl_flush_valid,
  .tbl_flush_index, .tbl_flush_dynamic, .tbl_flush_static, .tbl_flush_scope, .tbl_flush_port);

// ==== lookup_pkg.sv ====
// shared constants and types for the lookup engine control block
package lookup_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [11:0] CTRL1_IDX = 12'h0311;
  localparam logic [11:0] CTRL2_IDX = 12'h0312;
  localparam logic [11:0] INST_IDX  = 12'h03f0;
  localparam logic [11:0] CTRL1_ADDR = {CTRL1_IDX[9:0], 2'b00};
  localparam logic [11:0] CTRL2_ADDR = {CTRL2_IDX[9:0], 2'b00};
  localparam logic [11:0] INST_ADDR  = {INST_IDX[9:0], 2'b00};

  // control one bit positions
  localparam int unsigned BIT_LEARN_DIS  = 7;
  localparam int unsigned BIT_SELF_FILT  = 6;
  localparam int unsigned BIT_FLUSH_ALL  = 5;
  localparam int unsigned BIT_FLUSH_INST = 4;
  localparam int unsigned BIT_MC_FWD     = 3;
  localparam int unsigned BIT_AGE_EN     = 2;
  localparam int unsigned BIT_FAST_AGE   = 1;
  localparam int unsigned BIT_LINK_FLUSH = 0;

  // control two flush option field
  localparam int unsigned FLUSH_OPT_LSB = 2;

  localparam logic [7:0] CTRL1_RST = 8'h0c;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] INST_RST  = 8'h00;

  localparam logic [1:0] FLUSH_NONE = 2'h0;
  localparam logic [1:0] FLUSH_DYN  = 2'h1;
  localparam logic [1:0] FLUSH_STAT = 2'h2;
  localparam logic [1:0] FLUSH_BOTH = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SCOPE_ALL, SCOPE_INST, SCOPE_PORT} flush_scope_e;
  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL1, SEL_CTRL2, SEL_INST} reg_sel_e;

endpackage
